// >>> bench/rmw_ram_model.sv
/*
  Shared RAM model on the far side of the record writer's RAM port.
  Assumes one request at a time, held until it is acknowledged.
*/
`timescale 1ns/100ps
`default_nettype none
module rmw_ram_model (
  // Clock
  input wire logic clock_i,
  // Request side
  input wire rmw_pkg::rmw_ram_req_t req_i,
  input wire logic valid_i,
  input wire logic [1:0] delay_i,
  output logic ack_o,
  output logic [15:0] rdata_o,
  // Count of words written
  output logic [15:0] cnt_o
);
  logic [15:0] mem [0:8191];
  logic [1:0] wait_ff;
  initial begin
    ack_o = 1'b0;
    rdata_o = 16'h0000;
    cnt_o = 16'h0000;
    wait_ff = 2'h0;
  end
  always @(posedge clock_i) begin
    ack_o <= 1'b0;
    // Stale read data must not look valid outside an acknowledge
    rdata_o <= ~rdata_o;
    if (valid_i && !ack_o) begin
      if (wait_ff == delay_i) begin
        ack_o <= 1'b1;
        wait_ff <= 2'h0;
        if (req_i.we) begin
          mem[req_i.addr] <= req_i.wdata;
          cnt_o <= cnt_o + 16'h1;
        end else begin
          rdata_o <= mem[req_i.addr];
        end
      end else begin
        wait_ff <= wait_ff + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/rmw_record_writer_bench.sv
/*
  Self-checking bench of the receive mode record writer: corner and
  random mode commands, register access, record checks.
  Assumes the RAM model of rmw_ram_model.sv on the RAM port.
*/
`timescale 1ns/100ps
`default_nettype none
module rmw_record_writer_bench;
  logic clock_i = 0, nrst_i = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, cv = 0, busb = 0, bc = 0, ill = 0;
  logic dv = 0, ce = 0, se = 0, ex = 0, gp = 0, act = 0, done = 0;
  logic awready, wready, bvalid, arready, rvalid, ramv, ack;
  logic rv, inf, bsy, mdv;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp, dly = 0;
  logic [4:0] mc = 0;
  logic [15:0] dw = 0, tt = 0, rd16, mdata, wcnt;
  rmw_pkg::rmw_ram_req_t req;
  int num_errors = 0, n_tests = 0, cyc = 0, nmd = 0, emd = 0;
  logic [4:0] cmc [9] = '{5'h10, 5'h12, 5'h13, 5'h00, 5'h03, 5'h1f,
    5'h11, 5'h02, 5'h18};
  logic [15:0] ck [9] = '{16'h0004, 16'h0404, 16'h0004, 16'h0400,
    16'h0000, 16'h0004, 16'h1000, 16'h0900, 16'h0034};

  rmw_record_writer rmw_record_writer_i (
    .clock_i(clock_i), .nrst_i(nrst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .cmd_valid_i(cv), .cmd_mode_code_i(mc),
    .cmd_bus_b_i(busb), .cmd_broadcast_i(bc), .illegal_entry_i(ill),
    .data_valid_i(dv), .data_word_i(dw), .data_code_err_i(ce),
    .data_sync_err_i(se), .extra_word_i(ex), .gap_before_data_i(gp),
    .activity_after_i(act), .msg_done_i(done), .time_tag_i(tt),
    .ram_req_o(req), .ram_valid_o(ramv), .ram_ack_i(ack),
    .ram_rdata_i(rd16), .resp_valid_o(rv), .resp_in_form_o(inf),
    .resp_busy_o(bsy), .mode_data_valid_o(mdv), .mode_data_o(mdata));

  rmw_ram_model rmw_ram_model_i (.clock_i(clock_i), .req_i(req),
    .valid_i(ramv), .delay_i(dly), .ack_o(ack), .rdata_o(rd16),
    .cnt_o(wcnt));

  always #25 clock_i = ~clock_i;

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  // A hang ends in the closing report as a mismatch
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  always @(negedge clock_i) begin
    if (mdv === 1'b1) check(mdata, dw);
    if (mdv === 1'b1) nmd++;
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    logic pa, pw;
    pa = 1;
    pw = 1;
    @(posedge clock_i);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1;
    while (pa || pw) begin
      @(negedge clock_i);
      if (awready === 1'b1) pa = 0;
      if (wready === 1'b1) pw = 0;
      @(posedge clock_i);
      if (!pa) awvalid <= 0;
      if (!pw) wvalid <= 0;
    end
    bready <= 1;
    do @(negedge clock_i); while (bvalid !== 1'b1);
    check(bresp, er);
    @(posedge clock_i);
    bready <= 0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
    @(posedge clock_i);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(negedge clock_i); while (arready !== 1'b1);
    @(posedge clock_i);
    arvalid <= 0;
    do @(negedge clock_i); while (rvalid !== 1'b1);
    check(rdata, e);
    check(rresp, er);
    @(posedge clock_i);
    rready <= 0;
  endtask

  task automatic msg(input logic [4:0] m, input logic [15:0] k);
    logic [2:0] cf;
    logic [12:0] d, p;
    logic [15:0] info, c0, rw;
    logic undef, infm, busy, hd, e14, e13, e12, e11;
    cf = k[12:10];
    hd = k[2];
    d = 13'h0100 + {6'h00, m, 2'b00};
    p = {1'b1, 10'($urandom), 2'b00};
    undef = !m[4] || m == rmw_pkg::MC_UNDEF_A || m == rmw_pkg::MC_UNDEF_B
      || m == rmw_pkg::MC_UNDEF_C;
    infm = !k[0] && !(undef && cf[0]);
    busy = infm && (cf[2] || k[1]);
    e14 = hd & k[3];
    e11 = hd & k[4];
    e12 = (m[4] != hd) | k[5];
    e13 = cf[1] ? k[8] : (k[6] | k[7]);
    info = {1'b0, e14, e13, e12, e11, e14 | e12 | e11 | (e13 & !cf[1]),
      busy, k[0], 2'b00, k[9], m};
    // Good mode data is handed on only when in form and not busy
    if (m[4] && hd && !info[10] && infm && !busy) emd++;
    axi_wr(rmw_pkg::REG_CONFIG, 32'(cf), rmw_pkg::RESP_OKAY);
    rmw_ram_model_i.mem[d] = {15'h0000, k[1]};
    rmw_ram_model_i.mem[d + 13'h1] = {3'h0, p};
    for (int i = 0; i < 3; i++) rmw_ram_model_i.mem[p + 13'(i)] = 16'hdead;
    c0 = wcnt;
    @(posedge clock_i);
    dly <= 2'($urandom); cv <= 1; mc <= m; busb <= k[9]; bc <= k[8];
    ill <= k[0];
    @(posedge clock_i);
    cv <= 0;
    do @(negedge clock_i); while (rv !== 1'b1);
    check(inf, infm);
    check(bsy, busy);
    @(posedge clock_i);
    dv <= hd; dw <= 16'($urandom); ce <= k[3] & hd; se <= k[4] & hd;
    @(posedge clock_i);
    dv <= 0; ce <= 0; se <= 0; ex <= k[5]; gp <= k[6]; act <= k[7];
    @(negedge clock_i);
    check(wcnt, c0);
    @(posedge clock_i);
    ex <= 0; gp <= 0; act <= 0; done <= 1; tt <= 16'($urandom);
    @(posedge clock_i);
    done <= 0;
    while (wcnt !== c0 + 16'(2 + m[4])) @(negedge clock_i);
    repeat (2) @(posedge clock_i);
    rw = rmw_ram_model_i.mem[p];
    check(rw[15:11], info[15:11]);
    check(rw[10:8], info[10:8]);
    check(rw[7:0], info[7:0]);
    check(rmw_ram_model_i.mem[p + 13'h1], tt);
    rw = rmw_ram_model_i.mem[p + 13'h2];
    check(rw, !m[4] ? 16'hdead : hd ? dw : 16'h0000);
    axi_rd(rmw_pkg::REG_LAST_INFO, {16'h0000, info}, rmw_pkg::RESP_OKAY);
  endtask

  initial begin
    void'($urandom(32'h3b1d));
    repeat (12) @(posedge clock_i);
    nrst_i <= 1;
    axi_rd(rmw_pkg::REG_CONFIG, 32'(rmw_pkg::CFG_RESET), 2'h0);
    axi_rd(rmw_pkg::REG_DESC_BASE, 32'(rmw_pkg::DESC_BASE_RESET), 2'h0);
    axi_wr(rmw_pkg::REG_DESC_BASE, 32'h100, rmw_pkg::RESP_OKAY);
    axi_wr(rmw_pkg::REG_LAST_INFO, 32'h1, rmw_pkg::RESP_SLVERR);
    axi_rd(8'h10, 32'h0, rmw_pkg::RESP_SLVERR);
    $display("register test done");
    foreach (cmc[i]) begin
      msg(cmc[i], ck[i]);
      $display("corner test %0d done", i);
    end
    for (int i = 0; i < 24; i++) begin
      msg(5'($urandom), 16'($urandom) & 16'h1fff);
      $display("random test %0d done", i);
    end
    axi_rd(rmw_pkg::REG_REC_COUNT, 32'd33, rmw_pkg::RESP_OKAY);
    check(nmd, emd);
    finish_test();
  end
endmodule
`default_nettype wire

// >>> hdl/rmw_record_writer.sv
/*
  Receive mode command record writer of a remote terminal: fetches the
  descriptor of each receive mode command, answers the command, gathers
  error and status bits, and after message completion writes the
  information word, time tag and, for codes 16-31, mode data word into shared RAM.
  Assumes the protocol decoder, illegalization lookup and time-tag
  counter run on clock_i; the RAM port acknowledges each request.
*/
// Function
// - Codes 0-15 store information and time tag only
// - Information word at pointer, time tag next
// - Codes 16-31 store data word at pointer+2
// - Received mode data acted on and saved
// - Record address from the command's descriptor pointer
// - Record words written only after message completion
// - Undefined codes 16,18,19 answered in form while unused_mode_invalid_bit is clear
// - Undefined codes 0-15 answered in form while unused_mode_invalid_bit is clear
// - Bit 14 on coding or parity error
// - Gap mode: bit 13 on gap or activity
// - Broadcast mode: bit 13 on broadcast message
// - Bit 12 on missing or extra word
// - Bit 11 on command sync in data
// - Bit 10 when any error bit set
// - Bit 9 when answered busy
// - Bit 8 when illegalization entry is one
// - Bit 5 gives bus A or B
// - Bits 4-0 copy the mode code
`timescale 1ns/100ps
`default_nettype none

module rmw_record_writer #(
  parameter int AXI_AW = 8,
  parameter int PER_COMMAND_MAKE_BUSY_BIT_BIT = 0
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // AXI4-Lite slave
  input wire logic [AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [AXI_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Protocol events from the decoder
  input wire logic cmd_valid_i,
  input wire logic [4:0] cmd_mode_code_i,
  input wire logic cmd_bus_b_i,
  input wire logic cmd_broadcast_i,
  input wire logic illegal_entry_i,
  input wire logic data_valid_i,
  input wire logic [15:0] data_word_i,
  input wire logic data_code_err_i,
  input wire logic data_sync_err_i,
  input wire logic extra_word_i,
  input wire logic gap_before_data_i,
  input wire logic activity_after_i,
  input wire logic msg_done_i,
  input wire logic [15:0] time_tag_i,
  // Shared RAM port
  output rmw_pkg::rmw_ram_req_t ram_req_o,
  output logic ram_valid_o,
  input wire logic ram_ack_i,
  input wire logic [15:0] ram_rdata_i,
  // Status word answer and mode data action
  output logic resp_valid_o,
  output logic resp_in_form_o,
  output logic resp_busy_o,
  output logic mode_data_valid_o,
  output logic [15:0] mode_data_o
);

  initial begin
    // Register decode reads address bits 7:0
    if (AXI_AW < 8 || PER_COMMAND_MAKE_BUSY_BIT_BIT < 0 || PER_COMMAND_MAKE_BUSY_BIT_BIT > 15) begin
      $error("rmw_record_writer: unsupported parameter value");
    end
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_CTRL,
    ST_RD_PTR,
    ST_WAIT_DONE,
    ST_WR_INFO,
    ST_WR_TAG,
    ST_WR_DATA
  } rmw_state_t;

  localparam int RAW = rmw_pkg::RAM_AW;

  function automatic logic is_undefined(input logic [4:0] mc);
    is_undefined = !mc[rmw_pkg::MC_WITH_DATA_BIT] ||
      mc == rmw_pkg::MC_UNDEF_A || mc == rmw_pkg::MC_UNDEF_B ||
      mc == rmw_pkg::MC_UNDEF_C;
  endfunction

  function automatic logic [RAW-1:0] desc_addr(input logic [RAW-1:0] base,
      input logic [4:0] mc, input logic [RAW-1:0] ofs);
    desc_addr = base + (RAW'(mc) << rmw_pkg::DESC_SHIFT) + ofs;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  localparam int CFG_W_L = rmw_pkg::CFG_W;
  rmw_state_t st_ff;
  logic [CFG_W_L-1:0] cfg_ff;
  logic [RAW-1:0] desc_base_ff;
  logic [15:0] last_info_ff;
  logic [15:0] rec_count_ff;
  logic [4:0] mc_ff;
  logic bus_b_ff, bcast_ff, illegal_ff, per_command_make_busy_bit_ff;
  logic data_seen_ff, code_err_ff, sync_err_ff, extra_ff;
  logic gap_ff, act_after_ff, done_seen_ff;
  logic [15:0] data_ff, tag_ff;
  logic [RAW-1:0] dptr_ff;
  logic aw_held_ff, w_held_ff;
  logic [AXI_AW-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;

  // Derived command properties
  logic with_data, unused_mode_invalid_bit, bcast_sel, busy_now, in_form, wr_fire;
  rmw_pkg::rmw_info_word_t info;
  assign with_data = mc_ff[rmw_pkg::MC_WITH_DATA_BIT];
  assign unused_mode_invalid_bit = cfg_ff[rmw_pkg::CFG_UNUSED_MODE_INVALID_BIT_BIT];
  assign bcast_sel = cfg_ff[rmw_pkg::CFG_BCAST_SEL_BIT];
  assign busy_now = cfg_ff[rmw_pkg::CFG_GLOBAL_BUSY_BIT] ||
    ram_rdata_i[PER_COMMAND_MAKE_BUSY_BIT_BIT];
  assign in_form = !illegal_ff && !(is_undefined(mc_ff) && unused_mode_invalid_bit);
  assign wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid_o;

  // Information word assembly
  always_comb begin
    info = '0;
    info.invalid_word_error = code_err_ff;
    info.gap_or_broadcast_flag = bcast_sel ? bcast_ff :
      (gap_ff || act_after_ff);
    info.word_count_error = extra_ff ||
      (with_data != data_seen_ff);
    info.sync_type_error = sync_err_ff;
    info.message_error_flag = info.invalid_word_error ||
      info.word_count_error || info.sync_type_error ||
      (!bcast_sel && info.gap_or_broadcast_flag);
    info.answered_busy_flag = per_command_make_busy_bit_ff;
    info.illegal_command_flag = illegal_ff;
    info.bus_identity_bit = bus_b_ff;
    info.mode_code_field = mc_ff;
  end

  // Command capture and message flags; illegal entries are trusted as
  // loaded by the host
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mc_ff <= 5'h00;
      bus_b_ff <= 1'b0;
      bcast_ff <= 1'b0;
      illegal_ff <= 1'b0;
      data_seen_ff <= 1'b0;
      code_err_ff <= 1'b0;
      sync_err_ff <= 1'b0;
      extra_ff <= 1'b0;
      gap_ff <= 1'b0;
      act_after_ff <= 1'b0;
      done_seen_ff <= 1'b0;
      data_ff <= 16'h0000;
      tag_ff <= 16'h0000;
    end else if (st_ff == ST_IDLE) begin
      if (cmd_valid_i) begin
        mc_ff <= cmd_mode_code_i;
        bus_b_ff <= cmd_bus_b_i;
        bcast_ff <= cmd_broadcast_i;
        illegal_ff <= illegal_entry_i;
        data_seen_ff <= 1'b0;
        code_err_ff <= 1'b0;
        sync_err_ff <= 1'b0;
        extra_ff <= 1'b0;
        gap_ff <= 1'b0;
        act_after_ff <= 1'b0;
        done_seen_ff <= 1'b0;
      end
    end else if (!done_seen_ff) begin
      if (data_valid_i) begin
        extra_ff <= extra_ff || data_seen_ff;
        data_seen_ff <= 1'b1;
        data_ff <= data_word_i;
        code_err_ff <= code_err_ff || data_code_err_i;
        sync_err_ff <= sync_err_ff || data_sync_err_i;
      end
      extra_ff <= extra_ff || extra_word_i ||
        (data_valid_i && data_seen_ff);
      gap_ff <= gap_ff || gap_before_data_i;
      act_after_ff <= act_after_ff || activity_after_i;
      if (msg_done_i) begin
        done_seen_ff <= 1'b1;
        tag_ff <= time_tag_i;
      end
    end
  end

  // Record sequencer and shared RAM port
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= ST_IDLE;
      ram_valid_o <= 1'b0;
      ram_req_o <= '0;
      dptr_ff <= '0;
      per_command_make_busy_bit_ff <= 1'b0;
      resp_valid_o <= 1'b0;
      resp_in_form_o <= 1'b0;
      resp_busy_o <= 1'b0;
      mode_data_valid_o <= 1'b0;
      mode_data_o <= 16'h0000;
    end else begin
      resp_valid_o <= 1'b0;
      mode_data_valid_o <= 1'b0;
      case (st_ff)
        ST_IDLE: begin
          if (cmd_valid_i) begin
            st_ff <= ST_RD_CTRL;
          end
        end
        ST_RD_CTRL: begin
          if (!ram_valid_o) begin
            ram_valid_o <= 1'b1;
            ram_req_o <= {1'b0, desc_addr(desc_base_ff, mc_ff,
              rmw_pkg::DESC_CTRL_OFS), 16'h0000};
          end else if (ram_ack_i) begin
            ram_valid_o <= 1'b0;
            per_command_make_busy_bit_ff <= in_form && busy_now;
            resp_valid_o <= 1'b1;
            resp_in_form_o <= in_form;
            resp_busy_o <= in_form && busy_now;
            st_ff <= ST_RD_PTR;
          end
        end
        ST_RD_PTR: begin
          if (!ram_valid_o) begin
            ram_valid_o <= 1'b1;
            ram_req_o <= {1'b0, desc_addr(desc_base_ff, mc_ff,
              rmw_pkg::DESC_PTR_OFS), 16'h0000};
          end else if (ram_ack_i) begin
            ram_valid_o <= 1'b0;
            dptr_ff <= ram_rdata_i[RAW-1:0];
            st_ff <= ST_WAIT_DONE;
          end
        end
        ST_WAIT_DONE: begin
          // Nothing reaches the record before the message ends
          if (done_seen_ff) begin
            st_ff <= ST_WR_INFO;
            if (with_data && data_seen_ff && !info.message_error_flag &&
                in_form && !per_command_make_busy_bit_ff) begin
              mode_data_valid_o <= 1'b1;
              mode_data_o <= data_ff;
            end
          end
        end
        ST_WR_INFO: begin
          if (!ram_valid_o) begin
            ram_valid_o <= 1'b1;
            ram_req_o <= {1'b1, dptr_ff + rmw_pkg::REC_INFO_OFS,
              info};
          end else if (ram_ack_i) begin
            ram_valid_o <= 1'b0;
            st_ff <= ST_WR_TAG;
          end
        end
        ST_WR_TAG: begin
          if (!ram_valid_o) begin
            ram_valid_o <= 1'b1;
            ram_req_o <= {1'b1, dptr_ff + rmw_pkg::REC_TAG_OFS,
              tag_ff};
          end else if (ram_ack_i) begin
            ram_valid_o <= 1'b0;
            st_ff <= with_data ? ST_WR_DATA : ST_IDLE;
          end
        end
        ST_WR_DATA: begin
          if (!ram_valid_o) begin
            ram_valid_o <= 1'b1;
            // A missing word still leaves the slot written, as zero
            ram_req_o <= {1'b1, dptr_ff + rmw_pkg::REC_DATA_OFS,
              data_seen_ff ? data_ff : 16'h0000};
          end else if (ram_ack_i) begin
            ram_valid_o <= 1'b0;
            st_ff <= ST_IDLE;
          end
        end
        default: begin
          st_ff <= ST_IDLE;
          ram_valid_o <= 1'b0;
        end
      endcase
    end
  end

  // Software visible status
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_info_ff <= 16'h0000;
      rec_count_ff <= 16'h0000;
    end else if (st_ff == ST_WR_INFO && ram_valid_o && ram_ack_i) begin
      last_info_ff <= info;
      rec_count_ff <= rec_count_ff + 16'h0001;
    end
  end

  // Configuration registers
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_ff <= rmw_pkg::CFG_RESET;
      desc_base_ff <= rmw_pkg::DESC_BASE_RESET;
    end else if (wr_fire) begin
      if (awaddr_ff[7:0] == rmw_pkg::REG_CONFIG) begin
        cfg_ff <= CFG_W_L'(merge(32'(cfg_ff), wdata_ff, wstrb_ff));
      end
      if (awaddr_ff[7:0] == rmw_pkg::REG_DESC_BASE) begin
        desc_base_ff <= RAW'(merge(32'(desc_base_ff), wdata_ff, wstrb_ff));
      end
    end
  end

  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    mapped = a[7:0] == rmw_pkg::REG_CONFIG ||
      a[7:0] == rmw_pkg::REG_DESC_BASE ||
      a[7:0] == rmw_pkg::REG_LAST_INFO ||
      a[7:0] == rmw_pkg::REG_REC_COUNT;
  endfunction

  // AXI4-Lite write channels, address and data taken in either order
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= rmw_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        // Status words are read only; writing them is refused
        s_axi_bresp_o <= (awaddr_ff[7:0] == rmw_pkg::REG_CONFIG ||
          awaddr_ff[7:0] == rmw_pkg::REG_DESC_BASE) ?
          rmw_pkg::RESP_OKAY : rmw_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channels
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= rmw_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= mapped(s_axi_araddr_i) ? rmw_pkg::RESP_OKAY :
        rmw_pkg::RESP_SLVERR;
      case (s_axi_araddr_i[7:0])
        rmw_pkg::REG_CONFIG: s_axi_rdata_o <= 32'(cfg_ff);
        rmw_pkg::REG_DESC_BASE: s_axi_rdata_o <= 32'(desc_base_ff);
        rmw_pkg::REG_LAST_INFO: s_axi_rdata_o <= 32'(last_info_ff);
        rmw_pkg::REG_REC_COUNT: s_axi_rdata_o <= 32'(rec_count_ff);
        default: s_axi_rdata_o <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  rmw_pkg::rmw_info_word_t wr_info;
  assign wr_info = ram_req_o.wdata;

  AST_INFO_AT_POINTER: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ram_valid_o && st_ff == ST_WR_INFO |-> ram_req_o.we &&
      ram_req_o.addr == dptr_ff)
    else $error("Information word not at data pointer");
  AST_TAG_NEXT: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ram_valid_o && st_ff == ST_WR_TAG |-> ram_req_o.addr ==
      dptr_ff + rmw_pkg::REC_TAG_OFS && ram_req_o.wdata == tag_ff)
    else $error("Time tag not at pointer plus one");
  AST_DATA_PLUS_TWO: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ram_valid_o && st_ff == ST_WR_DATA |-> with_data &&
      ram_req_o.addr == dptr_ff + rmw_pkg::REC_DATA_OFS)
    else $error("Mode data word misplaced");
  AST_NO_DATA_SHORT: assert property (@(posedge clock_i) disable iff (!nrst_i)
    st_ff == ST_WR_TAG && ram_valid_o && ram_ack_i && !with_data
      |=> st_ff == ST_IDLE ##1 st_ff != ST_WR_DATA)
    else $error("Record without data grew a data word");
  AST_WRITE_AFTER_DONE: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ram_valid_o && ram_req_o.we |-> done_seen_ff)
    else $error("Record written before message completion");
  AST_PTR_FROM_DESC: assert property (@(posedge clock_i) disable iff (!nrst_i)
    st_ff == ST_RD_PTR && ram_valid_o && ram_ack_i |=>
      dptr_ff == $past(ram_rdata_i[RAW-1:0]) && st_ff == ST_WAIT_DONE)
    else $error("Data pointer not taken from descriptor");
  AST_MODE_FIELD: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ram_valid_o && st_ff == ST_WR_INFO |-> wr_info.mode_code_field == mc_ff
      && wr_info.bus_identity_bit == bus_b_ff)
    else $error("Mode code or bus identity wrong");
  AST_UNUSED_ZERO: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ram_valid_o && st_ff == ST_WR_INFO |-> !wr_info.unused_15 &&
      wr_info.unused_7_6 == 2'h0)
    else $error("Unused information bits not zero");
  AST_MESSAGE_ERROR_FLAG_SUM: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ram_valid_o && st_ff == ST_WR_INFO && (wr_info.invalid_word_error ||
      wr_info.sync_type_error || wr_info.word_count_error)
      |-> wr_info.message_error_flag)
    else $error("Message error flag missing");
  AST_IN_FORM: assert property (@(posedge clock_i) disable iff (!nrst_i)
    resp_valid_o && !illegal_ff && !unused_mode_invalid_bit |-> resp_in_form_o)
    else $error("Undefined code not answered in form");
  AST_ILLEGAL_BIT: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ram_valid_o && st_ff == ST_WR_INFO |-> wr_info.illegal_command_flag ==
      illegal_ff && !(illegal_ff && resp_in_form_o))
    else $error("Illegal entry not honoured");

endmodule

`default_nettype wire

// >>> shared/rmw_pkg.sv
/*
  Package of the receive mode command record writer: register map,
  configuration fields, record and descriptor layout, message
  information word layout and the shared RAM request carrier.
  Assumes a shared RAM of 16-bit words with 8K locations.
*/
`default_nettype none
package rmw_pkg;

  // Shared RAM geometry
  localparam int RAM_AW = 13;
  localparam int RAM_DW = 16;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_DESC_BASE = 8'h04;
  localparam logic [7:0] REG_LAST_INFO = 8'h08;
  localparam logic [7:0] REG_REC_COUNT = 8'h0c;

  // Configuration register fields
  localparam int CFG_UNUSED_MODE_INVALID_BIT_BIT = 0;
  localparam int CFG_BCAST_SEL_BIT = 1;
  localparam int CFG_GLOBAL_BUSY_BIT = 2;
  localparam int CFG_W = 3;
  localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;
  localparam logic [RAM_AW-1:0] DESC_BASE_RESET = 13'h0000;

  // Descriptor block layout, four words per mode code
  localparam int DESC_SHIFT = 2;
  localparam logic [RAM_AW-1:0] DESC_CTRL_OFS = 13'h0000;
  localparam logic [RAM_AW-1:0] DESC_PTR_OFS = 13'h0001;

  // Record layout relative to the data pointer
  localparam logic [RAM_AW-1:0] REC_INFO_OFS = 13'h0000;
  localparam logic [RAM_AW-1:0] REC_TAG_OFS = 13'h0001;
  localparam logic [RAM_AW-1:0] REC_DATA_OFS = 13'h0002;

  // Mode codes
  localparam int MC_WITH_DATA_BIT = 4;
  localparam logic [4:0] MC_UNDEF_A = 5'h10;
  localparam logic [4:0] MC_UNDEF_B = 5'h12;
  localparam logic [4:0] MC_UNDEF_C = 5'h13;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Message information word, bit 15 down to bit 0
  typedef struct packed {
    logic unused_15;
    logic invalid_word_error;
    logic gap_or_broadcast_flag;
    logic word_count_error;
    logic sync_type_error;
    logic message_error_flag;
    logic answered_busy_flag;
    logic illegal_command_flag;
    logic [1:0] unused_7_6;
    logic bus_identity_bit;
    logic [4:0] mode_code_field;
  } rmw_info_word_t;

  // Shared RAM request
  typedef struct packed {
    logic we;
    logic [RAM_AW-1:0] addr;
    logic [RAM_DW-1:0] wdata;
  } rmw_ram_req_t;

endpackage
`default_nettype wire
